// File: mode_lp_consts.vh
// constants for the mode select and low-power controller
// included by mode_lp_ctrl.v; definitions only
`ifndef MODE_LP_CONSTS_VH
`define MODE_LP_CONSTS_VH
// avalon register word offsets (byte address = 4 * index)
`define REG_CTRL_IDX 2'h0
`define REG_STATUS_IDX 2'h1
`define REG_OPT_IDX 2'h2
// control register fields (stop and wait: write one to start, self clearing; timer ie is held)
`define CTRL_STOP_BIT 0
`define CTRL_WAIT_BIT 1
`define CTRL_TIMER_IE_BIT 2
// option byte one fields
`define OPT1_HALT_CONV_BIT 5
`define OPT1_RESET 8'h00
`define OPT2_RESET 8'h00
// low-power states
`define LP_RUN 3'h0
`define LP_STOP 3'h1
`define LP_HALT 3'h2
`define LP_WAIT 3'h3
`define LP_STAB 3'h4
// boot sequencer states
`define BT_IDLE 3'h0
`define BT_ERASE 3'h1
`define BT_BLANK 3'h2
`define BT_PROG 3'h3
`define BT_VERIFY 3'h4
`define BT_DONE 3'h5
// stabilization delay in bus clock cycles
`define STAB_CYCLES 4064
`define STAB_W 12
// default bootloader erase and blank-verify lengths in bus clock cycles
`define ERASE_CYCLES_DEF 64
`define BLANK_CYCLES_DEF 64
`endif

// File: mode_lp_ctrl.v
// operating mode select, bootloader sequencer and stop/halt/wait control
// assumes one 125 MHz clock, avalon-mm slave, pins synchronised here
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
`include "mode_lp_consts.vh"
module mode_lp_ctrl #(
  parameter STAB_COUNT = `STAB_CYCLES,
  parameter ADDR_W = 20,
  parameter ERASE_CYCLES = `ERASE_CYCLES_DEF,
  parameter BLANK_CYCLES = `BLANK_CYCLES_DEF
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_lvr_active,
  input wire i_irq_high_volt,
  input wire i_irq_n,
  input wire i_capture_input_pin,
  input wire i_erase_program_select_pin,
  input wire [7:0] i_port_a_n,
  input wire i_timer_irq,
  input wire [7:0] i_ext_mem_data,
  input wire i_ee_busy,
  input wire i_ee_verify_ok,
  input wire i_user_ee_wr_req,
  input wire [1:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  output reg o_boot_mode,
  output reg o_prog_led,
  output reg o_verify_led,
  output reg [ADDR_W-1:0] o_ext_mem_addr,
  output reg o_ee_wr,
  output reg [ADDR_W-1:0] o_ee_addr,
  output reg [7:0] o_ee_data,
  output reg o_ee_bulk_erase,
  output reg o_user_ee_wr_en,
  output reg o_osc_en,
  output reg o_rc_osc_en,
  output reg o_cpu_bus_clk_en,
  output reg o_timer_clk_en,
  output reg o_int_mask_clr
);
  localparam integer STAB_LAST_I = STAB_COUNT - 1;
  localparam integer ERASE_LAST_I = ERASE_CYCLES - 1;
  localparam integer BLANK_LAST_I = BLANK_CYCLES - 1;
  localparam [`STAB_W-1:0] STAB_LAST = STAB_LAST_I[`STAB_W-1:0];
  localparam [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};
  localparam [15:0] ERASE_LAST = ERASE_LAST_I[15:0];
  localparam [15:0] BLANK_LAST = BLANK_LAST_I[15:0];

  // three-stage synchronisers for pins
  reg [2:0] s_hv_r, s_cap_r, s_sel_r, s_irq_r;
  reg hv_r, cap_r, sel_r, irq_n_r;
  wire [7:0] pa_n_r;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_hv_r <= 3'h0;
      s_cap_r <= 3'h0;
      s_sel_r <= 3'h0;
      s_irq_r <= 3'h7;
      hv_r <= 1'b0;
      cap_r <= 1'b0;
      sel_r <= 1'b0;
      irq_n_r <= 1'b1;
    end else begin
      s_hv_r <= {s_hv_r[1:0], i_irq_high_volt};
      s_cap_r <= {s_cap_r[1:0], i_capture_input_pin};
      s_sel_r <= {s_sel_r[1:0], i_erase_program_select_pin};
      s_irq_r <= {s_irq_r[1:0], i_irq_n};
      if (s_hv_r[2] == s_hv_r[1])
        hv_r <= s_hv_r[1];
      if (s_cap_r[2] == s_cap_r[1])
        cap_r <= s_cap_r[1];
      if (s_sel_r[2] == s_sel_r[1])
        sel_r <= s_sel_r[1];
      if (s_irq_r[2] == s_irq_r[1])
        irq_n_r <= s_irq_r[1];
    end
  end
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : pa_sync
      reg [2:0] sync_r;
      reg lvl_r;
      always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          sync_r <= 3'h7;
          lvl_r <= 1'b1;
        end else begin
          sync_r <= {sync_r[1:0], i_port_a_n[g]};
          if (sync_r[2] == sync_r[1])
            lvl_r <= sync_r[1];
        end
      end
      assign pa_n_r[g] = lvl_r;
    end
  endgenerate

  // reset release (external or low-voltage) seen as rising edge of run;
  // filtered like a pin so the pin levels have settled when mode is taken
  reg [2:0] lvr_sync_r;
  reg lvr_r, run_r, mode_done_r;
  wire in_reset = lvr_r;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvr_sync_r <= 3'h7;
      lvr_r <= 1'b1;
      run_r <= 1'b0;
    end else begin
      lvr_sync_r <= {lvr_sync_r[1:0], i_lvr_active};
      if (lvr_sync_r[2] == lvr_sync_r[1])
        lvr_r <= lvr_sync_r[1];
      run_r <= !in_reset;
    end
  end
  wire release_edge = !in_reset && !run_r;

  // option bytes, writable over the bus only in bootloader mode
  reg [7:0] opt1_r, opt2_r;
  reg timer_ie_r;
  wire halt_conv = opt1_r[`OPT1_HALT_CONV_BIT];

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_boot_mode <= 1'b0;
      mode_done_r <= 1'b0;
    end else if (in_reset) begin
      mode_done_r <= 1'b0;
    end else if (release_edge && !mode_done_r) begin
      // mode sampled at release of either reset
      o_boot_mode <= hv_r && cap_r;
      mode_done_r <= 1'b1; // held until the next reset
    end
  end

  // bootloader sequencer
  reg [2:0] bt_r;
  reg [15:0] bt_cnt_r;
  reg prog_sel_r, wr_pend_r;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bt_r <= `BT_IDLE;
      bt_cnt_r <= 16'h0000;
      prog_sel_r <= 1'b0;
      wr_pend_r <= 1'b0;
      o_prog_led <= 1'b0;
      o_verify_led <= 1'b0;
      o_ext_mem_addr <= {ADDR_W{1'b0}};
      o_ee_wr <= 1'b0;
      o_ee_addr <= {ADDR_W{1'b0}};
      o_ee_data <= 8'h00;
      o_ee_bulk_erase <= 1'b0;
    end else if (in_reset) begin
      bt_r <= `BT_IDLE;
      o_prog_led <= 1'b0;
      o_verify_led <= 1'b0;
      o_ee_wr <= 1'b0;
      o_ee_bulk_erase <= 1'b0;
    end else begin
      o_ee_wr <= 1'b0;
      case (bt_r)
        `BT_IDLE: begin
          if (mode_done_r && o_boot_mode) begin
            prog_sel_r <= sel_r;
            bt_r <= `BT_ERASE;
            bt_cnt_r <= 16'h0000;
            o_prog_led <= 1'b1;
            o_ee_bulk_erase <= 1'b1;
          end
        end
        `BT_ERASE: begin
          bt_cnt_r <= bt_cnt_r + 16'h0001;
          if (bt_cnt_r == ERASE_LAST) begin
            o_ee_bulk_erase <= 1'b0;
            bt_cnt_r <= 16'h0000;
            o_ext_mem_addr <= {ADDR_W{1'b0}};
            wr_pend_r <= 1'b0;
            if (prog_sel_r) begin
              bt_r <= `BT_PROG;
            end else begin
              o_prog_led <= 1'b0;
              bt_r <= `BT_BLANK;
            end
          end
        end
        `BT_BLANK: begin
          bt_cnt_r <= bt_cnt_r + 16'h0001;
          if (bt_cnt_r == BLANK_LAST && i_ee_verify_ok)
            bt_r <= `BT_DONE;
        end
        `BT_PROG: begin
          // copy one byte per write, wait for the array to go idle
          if (!i_ee_busy && !o_ee_wr) begin
            if (!wr_pend_r) begin
              o_ee_wr <= 1'b1;
              o_ee_addr <= o_ext_mem_addr;
              o_ee_data <= i_ext_mem_data;
              wr_pend_r <= 1'b1;
            end else if (o_ext_mem_addr == ADDR_LAST) begin
              o_prog_led <= 1'b0;
              bt_r <= `BT_VERIFY;
            end else begin
              o_ext_mem_addr <= o_ext_mem_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
              wr_pend_r <= 1'b0;
            end
          end
        end
        `BT_VERIFY: begin
          if (!i_ee_busy && i_ee_verify_ok)
            bt_r <= `BT_DONE;
        end
        `BT_DONE: begin
          o_verify_led <= 1'b1;
        end
        default: bt_r <= `BT_IDLE;
      endcase
    end
  end

  // small eeprom stays writable in user mode; main array only in boot
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      o_user_ee_wr_en <= 1'b0;
    else
      o_user_ee_wr_en <= i_user_ee_wr_req && !in_reset;
  end

  // stabilization counter, held at zero in stop, otherwise wraps every STAB_COUNT cycles
  reg [`STAB_W-1:0] stab_r;
  reg [2:0] lp_r;
  reg stop_req, wait_req;
  wire ext_int = !irq_n_r || !(&pa_n_r);
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      stab_r <= {`STAB_W{1'b0}};
    else if (lp_r == `LP_STOP)
      stab_r <= {`STAB_W{1'b0}};
    else if (stab_r == STAB_LAST)
      stab_r <= {`STAB_W{1'b0}};
    else
      stab_r <= stab_r + {{(`STAB_W-1){1'b0}}, 1'b1};
  end

  // low-power state machine
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lp_r <= `LP_RUN;
      o_osc_en <= 1'b1;
      o_rc_osc_en <= 1'b1;
      o_cpu_bus_clk_en <= 1'b0;
      o_timer_clk_en <= 1'b1;
      o_int_mask_clr <= 1'b0;
    end else if (in_reset) begin
      lp_r <= `LP_RUN; // reset also exits every low-power state
      o_osc_en <= 1'b1;
      o_rc_osc_en <= 1'b1;
      o_cpu_bus_clk_en <= 1'b0;
      o_timer_clk_en <= 1'b1;
      o_int_mask_clr <= 1'b0;
    end else begin
      o_int_mask_clr <= 1'b0;
      case (lp_r)
        `LP_RUN: begin
          o_cpu_bus_clk_en <= 1'b1;
          if (stop_req) begin
            o_int_mask_clr <= 1'b1;
            o_cpu_bus_clk_en <= 1'b0;
            if (halt_conv) begin
              lp_r <= `LP_HALT;
            end else begin
              lp_r <= `LP_STOP;
              o_osc_en <= 1'b0;
              o_rc_osc_en <= 1'b0;
              o_timer_clk_en <= 1'b0;
            end
          end else if (wait_req) begin
            o_int_mask_clr <= 1'b1;
            o_cpu_bus_clk_en <= 1'b0;
            lp_r <= `LP_WAIT;
          end
        end
        `LP_STOP: begin
          if (ext_int) begin
            o_osc_en <= 1'b1;
            o_rc_osc_en <= 1'b1;
            // timers run again with the oscillator, bus clock waits
            o_timer_clk_en <= 1'b1;
            lp_r <= `LP_STAB; // counter restarts from zero
          end
        end
        `LP_HALT: begin
          if (ext_int || (timer_ie_r && i_timer_irq))
            lp_r <= `LP_STAB; // remaining free-run count
        end
        `LP_WAIT: begin
          if (ext_int || (timer_ie_r && i_timer_irq)) begin
            o_cpu_bus_clk_en <= 1'b1;
            lp_r <= `LP_RUN;
          end
        end
        `LP_STAB: begin
          if (stab_r == STAB_LAST) begin
            o_timer_clk_en <= 1'b1;
            o_cpu_bus_clk_en <= 1'b1;
            lp_r <= `LP_RUN;
          end
        end
        default: lp_r <= `LP_RUN;
      endcase
    end
  end

  // avalon slave: one wait cycle, answer in the second cycle
  reg ack_r;
  wire req = (i_avs_read || i_avs_write) && !ack_r;
  wire wr_now = i_avs_write && ack_r;
  always @* begin
    stop_req = wr_now && i_avs_address == `REG_CTRL_IDX && i_avs_byteenable[0] &&
      i_avs_writedata[`CTRL_STOP_BIT];
    wait_req = wr_now && i_avs_address == `REG_CTRL_IDX && i_avs_byteenable[0] &&
      i_avs_writedata[`CTRL_WAIT_BIT] && !i_avs_writedata[`CTRL_STOP_BIT];
  end
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_r <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      opt1_r <= `OPT1_RESET;
      opt2_r <= `OPT2_RESET;
      timer_ie_r <= 1'b0;
    end else begin
      ack_r <= req;
      o_avs_waitrequest <= !req;
      if (wr_now && i_avs_byteenable[0]) begin
        if (i_avs_address == `REG_CTRL_IDX)
          timer_ie_r <= i_avs_writedata[`CTRL_TIMER_IE_BIT];
        if (i_avs_address == `REG_OPT_IDX && o_boot_mode)
          opt1_r <= i_avs_writedata[7:0];
      end
      if (wr_now && i_avs_byteenable[1] && i_avs_address == `REG_OPT_IDX && o_boot_mode)
        opt2_r <= i_avs_writedata[15:8];
      if (req && i_avs_read) begin
        case (i_avs_address)
          `REG_CTRL_IDX: o_avs_readdata <= {29'h0, timer_ie_r, 2'h0};
          `REG_STATUS_IDX: o_avs_readdata <= {22'h0, bt_r, lp_r, o_verify_led,
            o_prog_led, o_boot_mode, o_cpu_bus_clk_en};
          `REG_OPT_IDX: o_avs_readdata <= {16'h0, opt2_r, opt1_r};
          default: o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: mode_lp_checker.sv
// port checker for mode_lp_ctrl
// assumes a bind onto every mode_lp_ctrl instance
`timescale 1ns/1ns
module mode_lp_checker (
  input wire i_clk,
  input wire i_rstn,
  input wire i_lvr_active,
  input wire i_irq_n,
  input wire o_avs_waitrequest,
  input wire o_boot_mode,
  input wire o_prog_led,
  input wire o_verify_led,
  input wire o_ee_wr,
  input wire o_osc_en,
  input wire o_rc_osc_en,
  input wire o_cpu_bus_clk_en,
  input wire o_timer_clk_en,
  input wire o_int_mask_clr
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  reg [3:0] up_r;
  // cycles since the last reset of either kind ended
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      up_r <= 4'h0;
    else if (i_lvr_active)
      up_r <= 4'h0;
    else if (up_r != 4'hF)
      up_r <= up_r + 4'h1;
  end
  a_mode_held: assert property (up_r == 4'hF |-> $stable(o_boot_mode))
    else $error("mode changed without reset");
  a_ee_boot_only: assert property (o_ee_wr |-> o_boot_mode)
    else $error("array write outside bootloader");
  a_stop_osc_off: assert property (!o_osc_en |-> !o_rc_osc_en && !o_cpu_bus_clk_en)
    else $error("clock left running in stop");
  a_gated_timer_on: assert property (o_osc_en && !o_cpu_bus_clk_en |-> o_timer_clk_en)
    else $error("timer clock off while bus clock gated");
  a_stop_wake: assert property (!o_osc_en && !i_irq_n |-> ##[1:8] o_osc_en)
    else $error("no wake from stop");
  a_stop_delay: assert property ($rose(o_osc_en) |-> !o_cpu_bus_clk_en [*8])
    else $error("bus clock early after stop");
  a_mask_pulse: assert property (o_int_mask_clr |=> !o_int_mask_clr ##[0:3] !o_cpu_bus_clk_en)
    else $error("mask clear pulse wrong");
  a_ack_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  a_verify_prog: assert property (o_verify_led |-> !o_prog_led)
    else $error("both lights on");
endmodule
bind mode_lp_ctrl mode_lp_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_lvr_active(i_lvr_active), .i_irq_n(i_irq_n), .o_avs_waitrequest(o_avs_waitrequest),
  .o_boot_mode(o_boot_mode), .o_prog_led(o_prog_led), .o_verify_led(o_verify_led),
  .o_ee_wr(o_ee_wr), .o_osc_en(o_osc_en), .o_rc_osc_en(o_rc_osc_en),
  .o_cpu_bus_clk_en(o_cpu_bus_clk_en), .o_timer_clk_en(o_timer_clk_en),
  .o_int_mask_clr(o_int_mask_clr));

// File: boot_far_model.sv
// far side of the boot path: external code memory and eeprom array
// assumes a 4-bit address from the controller on i_clk
`timescale 1ns/1ns
module boot_far_model (
  input wire i_clk,
  input wire [3:0] i_addr,
  input wire i_ee_wr,
  output wire [7:0] o_data,
  output wire o_busy,
  output wire o_verify_ok
);
  reg [1:0] busy_r = 2'h0;
  // code image seen through the memory port
  assign o_data = {~i_addr, i_addr};
  // array stays busy two cycles after each write
  always @(posedge i_clk) begin
    busy_r <= i_ee_wr ? 2'h2 : (busy_r != 2'h0 ? busy_r - 2'h1 : 2'h0);
  end
  assign o_busy = busy_r != 2'h0;
  assign o_verify_ok = 1'h1;
endmodule

// File: tb_top.sv
// testbench for mode_lp_ctrl: boot runs, option bytes, stop, halt, wait
// assumes STAB_COUNT 16, erase and blank 4, ADDR_W 4
`timescale 1ns/1ns
module tb_top;
  logic i_clk = 1'h0, i_rstn = 1'h0, i_lvr_active = 1'h0, i_irq_high_volt = 1'h0;
  logic i_irq_n = 1'h1, i_capture_input_pin = 1'h1, i_erase_program_select_pin = 1'h0;
  logic i_timer_irq = 1'h0, i_user_ee_wr_req = 1'h0, i_avs_read = 1'h0, i_avs_write = 1'h0;
  logic [7:0] i_port_a_n = 8'hFF;
  logic [1:0] i_avs_address = 2'h0;
  logic [31:0] i_avs_writedata = 32'h0, r;
  wire [31:0] o_avs_readdata;
  wire o_avs_waitrequest, o_boot_mode, o_prog_led, o_verify_led, o_ee_wr, o_ee_bulk_erase;
  wire o_user_ee_wr_en, o_osc_en, o_rc_osc_en, o_cpu_bus_clk_en, o_timer_clk_en;
  wire o_int_mask_clr, busy, vok;
  wire [3:0] o_ext_mem_addr, o_ee_addr;
  wire [7:0] o_ee_data, mem_data;
  int failures = 0, comparisons = 0, n;
  int ers = 0, wrs = 0, mcl = 0;
  logic [31:0] eq[$], mq[$];
  always #4 i_clk = ~i_clk;
  mode_lp_ctrl #(.STAB_COUNT(16), .ADDR_W(4), .ERASE_CYCLES(4), .BLANK_CYCLES(4)) u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_lvr_active(i_lvr_active),
    .i_irq_high_volt(i_irq_high_volt), .i_irq_n(i_irq_n),
    .i_capture_input_pin(i_capture_input_pin),
    .i_erase_program_select_pin(i_erase_program_select_pin), .i_port_a_n(i_port_a_n),
    .i_timer_irq(i_timer_irq), .i_ext_mem_data(mem_data), .i_ee_busy(busy),
    .i_ee_verify_ok(vok), .i_user_ee_wr_req(i_user_ee_wr_req),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .o_boot_mode(o_boot_mode), .o_prog_led(o_prog_led), .o_verify_led(o_verify_led),
    .o_ext_mem_addr(o_ext_mem_addr), .o_ee_wr(o_ee_wr), .o_ee_addr(o_ee_addr),
    .o_ee_data(o_ee_data), .o_ee_bulk_erase(o_ee_bulk_erase),
    .o_user_ee_wr_en(o_user_ee_wr_en), .o_osc_en(o_osc_en), .o_rc_osc_en(o_rc_osc_en),
    .o_cpu_bus_clk_en(o_cpu_bus_clk_en), .o_timer_clk_en(o_timer_clk_en),
    .o_int_mask_clr(o_int_mask_clr));
  boot_far_model u_far (.i_clk(i_clk), .i_addr(o_ext_mem_addr), .i_ee_wr(o_ee_wr),
    .o_data(mem_data), .o_busy(busy), .o_verify_ok(vok));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge i_clk) begin
    if (i_avs_read && o_avs_waitrequest === 1'h0 && eq.size() > 0)
      check(o_avs_readdata & mq.pop_front(), eq.pop_front());
    if (o_ee_wr === 1'h1) begin
      wrs++;
      check({24'h0, o_ee_data}, {24'h0, ~o_ee_addr, o_ee_addr});
    end
    if (o_ee_bulk_erase === 1'h1)
      ers++;
    if (o_int_mask_clr === 1'h1)
      mcl++;
  end
  task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d, e, m);
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    @(posedge i_clk);
    while (o_avs_waitrequest !== 1'h0) @(posedge i_clk);
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rst(input logic hv, input logic sel);
    i_rstn <= 1'h0;
    i_erase_program_select_pin <= sel;
    repeat (2) @(posedge i_clk);
    i_irq_high_volt <= hv;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'h1;
    repeat (6) @(posedge i_clk);
  endtask
  task automatic wake(input int lim);
    for (n = 0; n < lim && o_cpu_bus_clk_en !== 1'h1; n++) @(posedge i_clk);
  endtask
  task automatic print_verdict;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    print_verdict;
  end
  initial begin
    r = $urandom(32'hCCFDA8EB);
    for (int s = 0; s < 2; s++) begin
      ers = 0;
      wrs = 0;
      rst(1'h1, s[0]);
      for (n = 0; n < 400 && o_verify_led !== 1'h1; n++) @(posedge i_clk);
      acc(1'h0, 2'h1, 32'h0, 32'hA, 32'hE);
      check(ers, 32'h4);
      check(wrs, s[0] ? 32'h10 : 32'h0);
    end
    r = ($urandom & 32'hFF00) | 32'h20;
    acc(1'h1, 2'h2, r, 32'h0, 32'h0);
    acc(1'h0, 2'h2, 32'h0, r, 32'hFFFF);
    acc(1'h0, 2'h3, 32'h0, 32'h0, 32'hFFFFFFFF);
    acc(1'h1, 2'h0, 32'h5, 32'h0, 32'h0);
    repeat (3) @(posedge i_clk);
    check({o_osc_en, o_cpu_bus_clk_en, o_timer_clk_en}, 32'h5);
    i_timer_irq <= 1'h1;
    wake(40);
    check(n > 0 && n < 22, 32'h1);
    i_timer_irq <= 1'h0;
    rst(1'h0, 1'h0);
    i_irq_high_volt <= 1'h1;
    acc(1'h1, 2'h2, 32'h20, 32'h0, 32'h0);
    acc(1'h0, 2'h2, 32'h0, 32'h0, 32'hFF);
    acc(1'h0, 2'h1, 32'h0, 32'h1, 32'h3);
    acc(1'h1, 2'h0, 32'h6, 32'h0, 32'h0);
    repeat (3) @(posedge i_clk);
    check({o_osc_en, o_cpu_bus_clk_en, o_timer_clk_en}, 32'h5);
    i_timer_irq <= 1'h1;
    wake(40);
    check(n < 4, 32'h1);
    i_timer_irq <= 1'h0;
    acc(1'h1, 2'h0, 32'h5, 32'h0, 32'h0);
    i_timer_irq <= 1'h1;
    repeat (10) @(posedge i_clk);
    check({o_osc_en, o_rc_osc_en, o_cpu_bus_clk_en}, 32'h0);
    i_timer_irq <= 1'h0;
    i_irq_n <= 1'h0;
    wake(60);
    check(n >= 16 && n < 30, 32'h1);
    i_irq_n <= 1'h1;
    i_user_ee_wr_req <= 1'h1;
    repeat (2) @(posedge i_clk);
    check(o_user_ee_wr_en, 32'h1);
    i_user_ee_wr_req <= 1'h0;
    i_lvr_active <= 1'h1;
    repeat (4) @(posedge i_clk);
    i_lvr_active <= 1'h0;
    repeat (8) @(posedge i_clk);
    acc(1'h0, 2'h1, 32'h0, 32'h2, 32'h2);
    repeat (4) @(posedge i_clk);
    check(mcl, 32'h3);
    print_verdict;
  end
endmodule
